/* File: core/foc_current_loop_front_end.sv */
/*
  Current-loop front end: APB registers, ADC selector and scaler, quadrature
  decoder with Hall start, two PI regulators, circular limiter, PWM with dead time.
  Assumes all pin inputs synchronous to clock_i; id_i/iq_i come from an outer transform.
*/
`timescale 1ns/10ps
module foc_current_loop_front_end (
  input  wire logic                clock_i,
  input  wire logic                srst_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic [31:0]              prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  input  wire logic [2:0][15:0]    adc_raw_i,
  input  wire logic                enc_a_i,
  input  wire logic                enc_b_i,
  input  wire logic [2:0]          hall_i,
  input  wire logic signed [15:0]  id_i,
  input  wire logic signed [15:0]  iq_i,
  output logic [2:0][15:0]         current_o,
  output logic [15:0]              position_o,
  output logic [15:0]              angle_o,
  output logic signed [15:0]       ud_o,
  output logic signed [15:0]       uq_o,
  output logic [2:0]               gate_high_o,
  output logic [2:0]               gate_low_o,
  output logic                     pwm_cycle_o
);
  logic [31:0]            ctrl, next_ctrl;
  foc_pkg::adc_scale_type scale [3];
  foc_pkg::adc_scale_type next_scale [3];
  logic [15:0]            period, next_period, dead, next_dead;
  logic [15:0]            positions_per_revolution, next_ppr, ulim, next_ulim;
  logic [7:0]             npp, next_npp;
  logic signed [15:0]     torque, next_torque;
  foc_pkg::pi_gain_type   gain_t, next_gain_t, gain_f, next_gain_f;
  logic [31:0]            next_rdata, rd;
  logic                   hit, wr;
  logic signed [15:0]     cur [3];
  logic signed [15:0]     next_cur [3];
  logic signed [15:0]     ld, lq, next_ld, next_lq;

  // register bus: zero wait states, read data captured in the setup cycle
  always_comb
  begin
    next_ctrl   = ctrl;
    next_scale  = scale;
    next_period = period;
    next_dead   = dead;
    next_npp    = npp;
    next_ppr    = positions_per_revolution;
    next_torque = torque;
    next_gain_t = gain_t;
    next_gain_f = gain_f;
    next_ulim   = ulim;
    hit         = 1'b1;
    rd          = '0;
    wr          = psel_i & penable_i & pwrite_i;
    case (paddr_i)
      foc_pkg::REG_CTRL:   rd = ctrl;
      foc_pkg::REG_SCALE0: rd = scale[0];
      foc_pkg::REG_SCALE1: rd = scale[1];
      foc_pkg::REG_SCALE2: rd = scale[2];
      foc_pkg::REG_PERIOD: rd = {16'h0000, period};
      foc_pkg::REG_DEAD:   rd = {16'h0000, dead};
      foc_pkg::REG_NPP:    rd = {24'h000000, npp};
      foc_pkg::REG_PPR:    rd = {16'h0000, positions_per_revolution};
      foc_pkg::REG_TORQUE: rd = {16'h0000, torque};
      foc_pkg::REG_GAIN_T: rd = gain_t;
      foc_pkg::REG_GAIN_F: rd = gain_f;
      foc_pkg::REG_ULIM:   rd = {16'h0000, ulim};
      foc_pkg::REG_POS:    rd = {angle_o, position_o};
      foc_pkg::REG_CUR01:  rd = {cur[1], cur[0]};
      foc_pkg::REG_CUR2:   rd = {16'h0000, cur[2]};
      foc_pkg::REG_VOLT:   rd = {lq, ld};
      default:             hit = 1'b0;
    endcase
    if (wr)
    begin
      case (paddr_i)
        foc_pkg::REG_CTRL:   next_ctrl = pwdata_i;
        foc_pkg::REG_SCALE0: next_scale[0] = pwdata_i;
        foc_pkg::REG_SCALE1: next_scale[1] = pwdata_i;
        foc_pkg::REG_SCALE2: next_scale[2] = pwdata_i;
        foc_pkg::REG_PERIOD: next_period = pwdata_i[15:0];
        foc_pkg::REG_DEAD:   next_dead = pwdata_i[15:0];
        foc_pkg::REG_NPP:    next_npp = pwdata_i[7:0];
        foc_pkg::REG_PPR:    next_ppr = pwdata_i[15:0];
        foc_pkg::REG_TORQUE: next_torque = pwdata_i[15:0];
        foc_pkg::REG_GAIN_T: next_gain_t = pwdata_i;
        foc_pkg::REG_GAIN_F: next_gain_f = pwdata_i;
        foc_pkg::REG_ULIM:   next_ulim = pwdata_i[15:0];
        default:             ;
      endcase
    end
    next_rdata = (psel_i && !penable_i) ? rd : prdata_o;
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~hit;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      ctrl     <= foc_pkg::CTRL_RST;
      scale    <= '{default: foc_pkg::SCALE_RST};
      period   <= foc_pkg::PERIOD_RST;
      dead     <= foc_pkg::DEAD_RST;
      npp      <= foc_pkg::NPP_RST;
      positions_per_revolution      <= foc_pkg::PPR_RST;
      torque   <= '0;
      gain_t   <= foc_pkg::GAIN_RST;
      gain_f   <= foc_pkg::GAIN_RST;
      ulim     <= foc_pkg::ULIM_RST;
      prdata_o <= '0;
      cur      <= '{default: 16'sh0000};
    end
    else
    begin
      ctrl     <= next_ctrl;
      scale    <= next_scale;
      period   <= next_period;
      dead     <= next_dead;
      npp      <= next_npp;
      positions_per_revolution      <= next_ppr;
      torque   <= next_torque;
      gain_t   <= next_gain_t;
      gain_f   <= next_gain_f;
      ulim     <= next_ulim;
      prdata_o <= next_rdata;
      cur      <= next_cur;
    end
  end

  // selector and scaler, one lane per phase
  for (genvar gi = 0; gi < foc_pkg::PHASES; gi++)
  begin : g_scale
    logic [1:0]         sel;
    logic [15:0]        raw;
    logic signed [16:0] diff;
    logic signed [32:0] prod;
    logic signed [32:0] shifted;
    assign sel  = ctrl[foc_pkg::CTRL_SEL_LSB + 2 * gi +: 2];
    assign raw  = (sel < 2'd3) ? adc_raw_i[sel] : adc_raw_i[0];
    // raw kept unsigned: a zero-extended subtract never misreads the top half
    assign diff = $signed({1'b0, raw}) - $signed({1'b0, scale[gi].offset});
    assign prod = diff * scale[gi].gain;
    assign shifted = prod >>> foc_pkg::SCALE_SHIFT;
    assign next_cur[gi] = ctrl[foc_pkg::CTRL_INV_LSB + gi] ? foc_pkg::sat16(-40'(shifted))
                                                           : foc_pkg::sat16(40'(shifted));
    assign current_o[gi] = cur[gi];
  end

  // quadrature decoder, position modulo positions_per_revolution
  logic [1:0]  code, code_q;
  logic [2:0]  hall_q, sector;
  logic        fwd, bwd, enc_up, enc_dn, hall_load, hall_done, next_hall_done;
  logic [15:0] pos, elec, next_pos, next_elec, hall_angle;
  logic [16:0] e_up;
  logic [35:0] hall_prod;

  function automatic logic [2:0] hall_sector(input logic [2:0] h);
    case (h)
      3'b001:  return 3'd0;
      3'b011:  return 3'd1;
      3'b010:  return 3'd2;
      3'b110:  return 3'd3;
      3'b100:  return 3'd4;
      3'b101:  return 3'd5;
      default: return 3'd7;
    endcase
  endfunction

  assign code       = {enc_b_i, enc_a_i ^ enc_b_i};
  assign fwd        = (code - code_q) == 2'd1;
  assign bwd        = (code - code_q) == 2'd3;
  assign enc_up     = ctrl[foc_pkg::CTRL_ENC_DIR] ? bwd : fwd;
  assign enc_dn     = ctrl[foc_pkg::CTRL_ENC_DIR] ? fwd : bwd;
  assign sector     = hall_sector(hall_i);
  assign hall_prod  = 36'(sector) * 36'(positions_per_revolution) * 36'(foc_pkg::SIXTH_Q16);
  assign hall_angle = hall_prod[31:16];
  assign hall_load  = (hall_i != hall_q) && ctrl[foc_pkg::CTRL_HALL] && !hall_done && sector != 3'd7;
  assign e_up       = {1'b0, elec} + {9'h000, npp};

  always_comb
  begin
    next_pos       = pos;
    next_elec      = elec;
    next_hall_done = ctrl[foc_pkg::CTRL_HALL] & (hall_done | hall_load);
    if (enc_up)
      next_pos = (pos >= positions_per_revolution - 16'h0001) ? 16'h0000 : pos + 16'h0001;
    else if (enc_dn)
      next_pos = (pos == 16'h0000) ? positions_per_revolution - 16'h0001 : pos - 16'h0001;
    // electrical angle steps by the pole-pair count per decoded position
    if (hall_load)
      next_elec = hall_angle;
    else if (enc_up)
      next_elec = (e_up >= {1'b0, positions_per_revolution}) ? 16'(e_up - {1'b0, positions_per_revolution}) : e_up[15:0];
    else if (enc_dn)
      next_elec = (elec < {8'h00, npp}) ? 16'(elec + positions_per_revolution - {8'h00, npp}) : 16'(elec - {8'h00, npp});
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      code_q    <= '0;
      hall_q    <= '0;
      hall_done <= 1'b0;
      pos       <= '0;
      elec      <= '0;
    end
    else
    begin
      code_q    <= code;
      hall_q    <= hall_i;
      hall_done <= next_hall_done;
      pos       <= next_pos;
      elec      <= next_elec;
    end
  end

  assign position_o = pos;
  assign angle_o    = elec;

  // regulators run once per modulator period
  logic               strobe, pq_valid, outside;
  logic signed [15:0] pd, pq;
  logic [31:0]        lim_prod, r2;
  logic [15:0]        radius;
  logic [32:0]        mag;

  pi_regulator u_torque (
    .clock_i  (clock_i),
    .srst_i   (srst_i),
    .update_i (strobe & ctrl[foc_pkg::CTRL_PI_EN]),
    .clear_i  (~ctrl[foc_pkg::CTRL_PI_EN]),
    .target_i (torque),
    .actual_i (iq_i),
    .gain_i   (gain_t),
    .out_o    (pq),
    .valid_o  (pq_valid)
  );

  pi_regulator u_flux (
    .clock_i  (clock_i),
    .srst_i   (srst_i),
    .update_i (strobe & ctrl[foc_pkg::CTRL_PI_EN]),
    .clear_i  (~ctrl[foc_pkg::CTRL_PI_EN]),
    .target_i (foc_pkg::FLUX_TARGET),
    .actual_i (id_i),
    .gain_i   (gain_f),
    .out_o    (pd),
    .valid_o  ()
  );

  // iterative shrink avoids a divider; settles within a few dozen cycles
  assign lim_prod = 32'(ulim) * 32'(foc_pkg::SQRT2_Q14);
  assign radius   = (|lim_prod[31:30]) ? 16'hffff : lim_prod[foc_pkg::SQRT2_FRAC +: 16];
  assign r2       = 32'(radius) * 32'(radius);
  assign mag      = {1'b0, 32'(ld * ld)} + {1'b0, 32'(lq * lq)};
  assign outside  = mag > {1'b0, r2};

  always_comb
  begin
    next_ld = ld;
    next_lq = lq;
    if (pq_valid)
    begin
      next_ld = pd;
      next_lq = pq;
    end
    else if (outside)
    begin
      next_ld = ld - (ld >>> foc_pkg::LIM_SHIFT);
      next_lq = lq - (lq >>> foc_pkg::LIM_SHIFT);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      ld <= '0;
      lq <= '0;
    end
    else
    begin
      ld <= next_ld;
      lq <= next_lq;
    end
  end

  assign ud_o = ld;
  assign uq_o = lq;

  // centre-aligned carrier; new period taken only at the valley
  logic [15:0]        cnt, next_cnt, period_act, next_period_act;
  logic               up, next_up;
  logic signed [15:0] vr [3];
  logic signed [15:0] vs [3];
  logic signed [15:0] mx, mn;
  logic signed [16:0] off;
  logic [2:0]         hs_all, ls_all;

  assign strobe      = !up && cnt == 16'h0000;
  assign pwm_cycle_o = strobe;

  always_comb
  begin
    next_cnt        = cnt + 16'h0001;
    next_up         = up;
    next_period_act = period_act;
    if (up && cnt >= period_act)
    begin
      next_up  = 1'b0;
      next_cnt = cnt - 16'h0001;
    end
    else if (!up && cnt != 16'h0000)
      next_cnt = cnt - 16'h0001;
    else if (!up)
    begin
      next_up         = 1'b1;
      next_period_act = (period == 16'h0000) ? foc_pkg::PERIOD_MIN : period;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      cnt        <= '0;
      up         <= 1'b1;
      period_act <= foc_pkg::PERIOD_RST;
    end
    else
    begin
      cnt        <= next_cnt;
      up         <= next_up;
      period_act <= next_period_act;
    end
  end

  always_comb
  begin
    vr[0] = ld;
    vr[1] = lq;
    vr[2] = foc_pkg::sat16(-40'(ld) - 40'(lq));
    mx    = vr[0];
    mn    = vr[0];
    for (int i = 1; i < foc_pkg::PHASES; i++)
    begin
      mx = (vr[i] > mx) ? vr[i] : mx;
      mn = (vr[i] < mn) ? vr[i] : mn;
    end
    off = -((17'(mx) + 17'(mn)) >>> 1);
    for (int i = 0; i < foc_pkg::PHASES; i++)
      vs[i] = ctrl[foc_pkg::CTRL_SPACE_VECTOR_MODULATION] ? foc_pkg::sat16(40'(vr[i]) + 40'(off)) : vr[i];
  end

  for (genvar gi = 0; gi < foc_pkg::PHASES; gi++)
  begin : g_phase
    logic signed [32:0] prod;
    logic signed [17:0] ref_lvl;
    logic               want, lvl, next_lvl, hs, ls, next_hs, next_ls;
    logic [7:0]         dtc, next_dtc;
    assign prod    = vs[gi] * $signed({1'b0, period_act});
    assign ref_lvl = $signed({2'b00, period_act[15:1]}) + 18'($signed(prod[32:17]));
    assign want    = $signed({2'b00, cnt}) < ref_lvl;

    // both switches off for the programmed pause before either turns on
    always_comb
    begin
      next_lvl = lvl;
      next_dtc = dtc;
      next_hs  = hs;
      next_ls  = ls;
      if (want != lvl)
      begin
        next_lvl = want;
        next_hs  = 1'b0;
        next_ls  = 1'b0;
        next_dtc = want ? dead[foc_pkg::DEAD_H_LSB +: 8] : dead[foc_pkg::DEAD_L_LSB +: 8];
      end
      else if (dtc != 8'h00)
        next_dtc = dtc - 8'h01;
      else
      begin
        next_hs = lvl;
        next_ls = !lvl;
      end
    end

    always_ff @(posedge clock_i)
    begin
      if (srst_i)
      begin
        lvl <= 1'b0;
        dtc <= '0;
        hs  <= 1'b0;
        ls  <= 1'b0;
      end
      else
      begin
        lvl <= next_lvl;
        dtc <= next_dtc;
        hs  <= next_hs;
        ls  <= next_ls;
      end
    end
    assign hs_all[gi] = hs;
    assign ls_all[gi] = ls;
  end

  assign gate_high_o = hs_all ^ {3{ctrl[foc_pkg::CTRL_POL_HIGH]}};
  assign gate_low_o  = ls_all ^ {3{ctrl[foc_pkg::CTRL_POL_LOW]}};

  property p_sat;
    @(posedge clock_i) disable iff (srst_i)
      (g_scale[0].shifted > 33'sd32767 && !ctrl[foc_pkg::CTRL_INV_LSB]) |=> cur[0] == foc_pkg::S16_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("scaler wrapped instead of clipping");

  property p_dir;
    @(posedge clock_i) disable iff (srst_i)
      (fwd && ctrl[foc_pkg::CTRL_ENC_DIR] && pos != 16'h0000) |=> pos == $past(pos) - 16'h0001;
  endproperty
  a_dir: assert property (p_dir) else $error("reversed count direction ignored");

  property p_elec;
    @(posedge clock_i) disable iff (srst_i)
      (enc_up && !hall_load && e_up < {1'b0, positions_per_revolution}) |=> elec == 16'($past(elec) + {8'h00, $past(npp)});
  endproperty
  a_elec: assert property (p_elec) else $error("electrical angle step wrong");

  property p_hall;
    @(posedge clock_i) disable iff (srst_i)
      hall_load |=> (elec == $past(hall_angle)) && hall_done;
  endproperty
  a_hall: assert property (p_hall) else $error("hall start angle not loaded");

  property p_dead;
    @(posedge clock_i) disable iff (srst_i)
      ($fell(ls_all[0]) && dead[foc_pkg::DEAD_H_LSB +: 8] >= 8'h08) |-> !hs_all[0] [*8];
  endproperty
  a_dead: assert property (p_dead) else $error("high side turned on inside pause");

  property p_pol;
    @(posedge clock_i) disable iff (srst_i)
      (gate_high_o[0] != ctrl[foc_pkg::CTRL_POL_HIGH]) |-> gate_low_o[0] == ctrl[foc_pkg::CTRL_POL_LOW];
  endproperty
  a_pol: assert property (p_pol) else $error("both switches of a leg active");

  property p_period;
    @(posedge clock_i) disable iff (srst_i)
      !strobe |=> $stable(period_act);
  endproperty
  a_period: assert property (p_period) else $error("period changed mid cycle");

  property p_lim;
    @(posedge clock_i) disable iff (srst_i)
      (!pq_valid && outside) |=> ld == $past(ld) - ($past(ld) >>> foc_pkg::LIM_SHIFT);
  endproperty
  a_lim: assert property (p_lim) else $error("limiter did not shrink");
endmodule // foc_current_loop_front_end

/* File: core/foc_pkg.sv */
/*
  Shared constants, register map, field layouts and register types of the
  current-loop front end. Assumes a 32-bit APB register bus with 8-bit byte addresses.
*/
// Notes on behaviour
// - raw phase sample is unsigned sixteen bit
// - offset removed, scaled into signed sixteen bit
// - per-phase numeric sign inversion in scaler
// - selector maps ADC channel to each phase
// - encoder count direction is programmable
// - first Hall edge loads sixty-degree angle
// - programmable period plus high/low dead times
// - control bits set gate output polarity
// - one bit enables space vector modulation
// - period changes live through one parameter
// - torque PI to target, flux PI to zero
// - circular limiter, radius root two times limit
// - pole pairs set electrical per mechanical turns
// - four positions per line, per-revolution in positions
// - gains q8.8 proportional, q0.15 integral
package foc_pkg;
  localparam int unsigned PHASES     = 3;
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_SCALE0 = 8'h04;
  localparam logic [7:0]  REG_SCALE1 = 8'h08;
  localparam logic [7:0]  REG_SCALE2 = 8'h0c;
  localparam logic [7:0]  REG_PERIOD = 8'h10;
  localparam logic [7:0]  REG_DEAD   = 8'h14;
  localparam logic [7:0]  REG_NPP    = 8'h18;
  localparam logic [7:0]  REG_PPR    = 8'h1c;
  localparam logic [7:0]  REG_TORQUE = 8'h20;
  localparam logic [7:0]  REG_GAIN_T = 8'h24;
  localparam logic [7:0]  REG_GAIN_F = 8'h28;
  localparam logic [7:0]  REG_ULIM   = 8'h2c;
  localparam logic [7:0]  REG_POS    = 8'h30;
  localparam logic [7:0]  REG_CUR01  = 8'h34;
  localparam logic [7:0]  REG_CUR2   = 8'h38;
  localparam logic [7:0]  REG_VOLT   = 8'h3c;

  localparam int unsigned CTRL_ENC_DIR  = 0;
  localparam int unsigned CTRL_HALL     = 1;
  localparam int unsigned CTRL_SPACE_VECTOR_MODULATION    = 2;
  localparam int unsigned CTRL_POL_HIGH = 3;
  localparam int unsigned CTRL_POL_LOW  = 4;
  localparam int unsigned CTRL_PI_EN    = 5;
  localparam int unsigned CTRL_INV_LSB  = 8;
  localparam int unsigned CTRL_SEL_LSB  = 16;
  localparam int unsigned DEAD_H_LSB    = 0;
  localparam int unsigned DEAD_L_LSB    = 8;

  typedef struct packed {
    logic signed [15:0] gain;
    logic [15:0]        offset;
  } adc_scale_type;

  typedef struct packed {
    logic signed [15:0] ki;
    logic signed [15:0] kp;
  } pi_gain_type;

  localparam logic [31:0]        CTRL_RST   = 32'h0024_0000;
  localparam adc_scale_type      SCALE_RST  = 32'h0100_8000;
  localparam pi_gain_type        GAIN_RST   = 32'h0000_0000;
  localparam logic [15:0]        PERIOD_RST = 16'h186a;
  localparam logic [15:0]        PERIOD_MIN = 16'h0001;
  localparam logic [15:0]        DEAD_RST   = 16'h0808;
  localparam logic [7:0]         NPP_RST    = 8'h01;
  localparam logic [15:0]        PPR_RST    = 16'h1000;
  localparam logic [15:0]        ULIM_RST   = 16'h5a82;
  localparam logic [15:0]        SQRT2_Q14  = 16'h5a82;
  localparam int unsigned        SQRT2_FRAC = 14;
  localparam logic [16:0]        SIXTH_Q16  = 17'h02aab;
  localparam int unsigned        SCALE_SHIFT = 8;
  localparam int unsigned        KP_FRAC    = 8;
  localparam int unsigned        KI_FRAC    = 15;
  localparam int unsigned        LIM_SHIFT  = 4;
  localparam logic signed [15:0] FLUX_TARGET = 16'sh0000;
  localparam logic signed [15:0] S16_MAX    = 16'sh7fff;
  localparam logic signed [15:0] S16_MIN    = 16'sh8000;

  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    if (v > S16_MAX)
      return S16_MAX;
    else if (v < S16_MIN)
      return S16_MIN;
    else
      return v[15:0];
  endfunction
endpackage

/* File: core/pi_regulator.sv */
/*
  One PI current regulator with saturating integrator and output.
  Assumes update_i pulses once per modulator period; clear_i holds it idle.
*/
`timescale 1ns/10ps
module pi_regulator (
  input  wire logic                 clock_i,
  input  wire logic                 srst_i,
  input  wire logic                 update_i,
  input  wire logic                 clear_i,
  input  wire logic signed [15:0]   target_i,
  input  wire logic signed [15:0]   actual_i,
  input  wire foc_pkg::pi_gain_type gain_i,
  output logic signed [15:0]        out_o,
  output logic                      valid_o
);
  logic signed [16:0] err;
  logic signed [32:0] pterm;
  logic signed [32:0] iterm;
  logic signed [15:0] integ;
  logic signed [15:0] next_integ;
  logic signed [15:0] next_out;
  logic               next_valid;

  assign err   = 17'(target_i) - 17'(actual_i);
  assign pterm = (err * gain_i.kp) >>> foc_pkg::KP_FRAC;
  assign iterm = (err * gain_i.ki) >>> foc_pkg::KI_FRAC;

  always_comb
  begin
    next_integ = integ;
    next_out   = out_o;
    next_valid = 1'b0;
    if (clear_i)
    begin
      next_integ = '0;
      next_out   = '0;
    end
    else if (update_i)
    begin
      next_integ = foc_pkg::sat16(40'(integ) + 40'(iterm));
      next_out   = foc_pkg::sat16(40'(pterm) + 40'(integ));
      next_valid = 1'b1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      integ   <= '0;
      out_o   <= '0;
      valid_o <= 1'b0;
    end
    else
    begin
      integ   <= next_integ;
      out_o   <= next_out;
      valid_o <= next_valid;
    end
  end

  property p_pi_hold;
    @(posedge clock_i) disable iff (srst_i)
      (update_i && !clear_i && err == 17'sh0) |=> integ == $past(integ);
  endproperty
  a_pi_hold: assert property (p_pi_hold) else $error("integrator moved with zero error");

  property p_pi_prop;
    @(posedge clock_i) disable iff (srst_i)
      (update_i && !clear_i && integ == 16'sh0 && pterm < 33'sd32767 && pterm > -33'sd32768)
      |=> (out_o == $past(pterm[15:0])) && valid_o;
  endproperty
  a_pi_prop: assert property (p_pi_prop) else $error("proportional term wrong");
endmodule // pi_regulator

/* File: verification/foc_current_loop_front_end_tb.sv */
/*
  Self-checking bench: APB registers, scaler, selector, encoder, PWM period.
  Assumes the partner model drives the encoder and Hall pins.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("unexpected t=%0t %h %h", $time, a, b); end end
module foc_current_loop_front_end_tb;
  logic             clock_i = 0;
  logic             srst_i = 1;
  logic             psel = 0, penable = 0, pwrite = 0, step = 0, back = 0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0, prdata, rd;
  logic             pready, pslverr, pcyc, err, enc_a, enc_b;
  logic [2:0]       hall, gh, gl;
  logic [2:0][15:0] raw = '0, cur;
  logic [15:0]      pos, iq = 16'h0000;
  int               error_cnt = 0, n_tests = 0, n;
  always #2 clock_i = ~clock_i;
  foc_partner foc_partner_i (.clock_i, .step_i(step), .back_i(back), .enc_a_o(enc_a), .enc_b_o(enc_b),
    .hall_o(hall));
  foc_current_loop_front_end foc_current_loop_front_end_i (.clock_i, .srst_i, .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .adc_raw_i(raw), .enc_a_i(enc_a), .enc_b_i(enc_b),
    .hall_i(hall), .id_i(16'sh0), .iq_i(iq), .current_o(cur), .position_o(pos), .angle_o(),
    .ud_o(), .uq_o(), .gate_high_o(gh), .gate_low_o(gl), .pwm_cycle_o(pcyc));
  // entered just after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1;
    do
    begin
      @(posedge clock_i);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clock_i);
  endtask
  task automatic t_regs;
    apb(0, 8'h00, 0);
    `CHK(rd, 32'h0024_0000)
    apb(0, 8'h10, 0);
    `CHK(rd, 32'h0000_186a)
    apb(0, 8'h14, 0);
    `CHK(rd, 32'h0000_0808)
    apb(0, 8'h44, 0);
    `CHK(err, 1'b1)
    $display("registers done");
  endtask
  task automatic t_scale;
    raw <= {16'h0000, 16'hffff, 16'h8123};
    repeat (3) @(posedge clock_i);
    `CHK(cur[0], 16'h0123)
    `CHK(cur[1], 16'h7fff)
    `CHK(cur[2], 16'h8000)
    // phase 0 from channel 2, inverted: +32768 must clip
    apb(1, 8'h00, 32'h0026_0100);
    repeat (3) @(posedge clock_i);
    `CHK(cur[0], 16'h7fff)
    apb(1, 8'h00, 32'h0024_0100);
    apb(1, 8'h04, 32'h0200_8000);
    repeat (3) @(posedge clock_i);
    apb(0, 8'h34, 0);
    `CHK(rd[15:0], 16'hfdba)
    apb(1, 8'h04, 32'h7fff_8000);
    repeat (3) @(posedge clock_i);
    `CHK(cur[0], 16'h8000)
    apb(1, 8'h00, 32'h0024_0000);
    repeat (3) @(posedge clock_i);
    `CHK(cur[0], 16'h7fff)
    $display("scaler done");
  endtask
  task automatic t_enc;
    repeat (4)
    begin
      step <= 1;
      @(posedge clock_i);
      step <= 0;
      @(posedge clock_i);
    end
    repeat (3) @(posedge clock_i);
    `CHK(pos, 16'h0004)
    apb(1, 8'h00, 32'h0024_0001);
    step <= 1;
    @(posedge clock_i);
    step <= 0;
    repeat (4) @(posedge clock_i);
    `CHK(pos, 16'h0003)
    $display("encoder done");
  endtask
  // new period lands at the next valley, then valleys come 2*period apart
  task automatic t_pwm;
    apb(1, 8'h10, 32'h0000_0004);
    n = 0;
    do
    begin
      @(negedge clock_i);
      n++;
    end
    while (pcyc !== 1'b1 && n < 20000);
    `CHK(pcyc, 1'b1)
    n = 0;
    do
    begin
      @(negedge clock_i);
      n++;
    end
    while (pcyc !== 1'b1 && n < 100);
    `CHK(n, 8)
    @(posedge clock_i);
    // pauses longer than each half cycle keep every switch off
    `CHK({gh, gl}, 6'h00)
    apb(1, 8'h00, 32'h0024_0018);
    `CHK({gh, gl}, 6'h3f)
    apb(1, 8'h00, 32'h0024_0000);
    $display("pwm done");
  endtask
  // angle stands at three steps of one pole pair until the first hall edge
  task automatic t_hall;
    apb(0, 8'h30, 0);
    `CHK(rd, 32'h0003_0003)
    apb(1, 8'h00, 32'h0024_0002);
    back <= 1;
    repeat (3) @(posedge clock_i);
    back <= 0;
    repeat (3) @(posedge clock_i);
    apb(0, 8'h30, 0);
    `CHK(rd, 32'h02aa_0003)
    apb(1, 8'h00, 32'h0024_0000);
    $display("hall done");
  endtask
  // kp of one, no integral; then a small limit shrinks the held voltage
  task automatic t_pi;
    iq <= 16'h0100;
    apb(1, 8'h24, 32'h0000_0100);
    apb(1, 8'h20, 32'h0000_0200);
    apb(1, 8'h00, 32'h0024_0020);
    repeat (24) @(posedge clock_i);
    apb(0, 8'h3c, 0);
    `CHK(rd, 32'h0100_0000)
    apb(1, 8'h2c, 32'h0000_0010);
    apb(1, 8'h00, 32'h0024_0000);
    repeat (80) @(posedge clock_i);
    apb(0, 8'h3c, 0);
    `CHK(rd, 32'h0016_0000)
    $display("regulators done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // tests need well under 30000 cycles
  initial
  begin
    #200000;
    error_cnt++;
    test_done();
  end
  initial
  begin
    repeat (8) @(posedge clock_i);
    srst_i <= 0;
    t_regs();
    t_scale();
    t_enc();
    t_hall();
    t_pwm();
    t_pi();
    test_done();
  end
endmodule // foc_current_loop_front_end_tb

/* File: verification/foc_partner.sv */
/*
  Far-side model: quadrature encoder and Hall sensors.
  Assumes step_i pulses come no closer than every other clock.
*/
`timescale 1ns/10ps
module foc_partner (
  input  wire logic  clock_i,
  input  wire logic  step_i,
  input  wire logic  back_i,
  output logic       enc_a_o,
  output logic       enc_b_o,
  output logic [2:0] hall_o
);
  logic [1:0] phase = 2'h0;
  // one phase step is one decoded position, four per line
  always_ff @(posedge clock_i)
    if (step_i)
      phase <= back_i ? phase - 2'h1 : phase + 2'h1;
  assign enc_b_o = phase[1];
  assign enc_a_o = phase[1] ^ phase[0];
  // rotor parked in the first sector; back_i nudges it into the next one
  assign hall_o  = back_i ? 3'h3 : 3'h1;
endmodule // foc_partner
